// ===== hw/acs_fifo.sv
// result buffer between the converter and the serial port
`timescale 1ns/100ps
`default_nettype none
module acs_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             ce_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      wr_next;
	logic [AW:0]      rd_reg;
	logic [AW:0]      rd_next;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready_out  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
		out_valid_out = wr_reg != rd_reg;
		out_data_out  = mem_reg[rd_reg[AW-1:0]];
		push          = in_valid_in & in_ready_out;
		pop           = out_ready_in & out_valid_out;
		wr_next       = push ? wr_reg + 1'b1 : wr_reg;
		rd_next       = pop ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else if (ce_in) begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// storage needs no reset; only the pointers define contents
	always_ff @(posedge clk_in) begin
		if (ce_in && push) begin
			mem_reg[wr_reg[AW-1:0]] <= in_data_in;
		end
	end
endmodule
`default_nettype wire

// ===== hw/acs_pkg.sv
// constants shared by the converter sequencer, its checks and its bench
package acs_pkg;
	localparam int          CONV_PERIODS     = 18;
	localparam int          CAL_FULL_PERIODS = 125013;
	localparam int          CAL_DAC_PERIODS  = 111114;
	localparam int          CAL_OFS_PERIODS  = 13899;
	localparam int          CNT_W            = 17;
	localparam int          DATA_W           = 12;
	localparam int          FIFO_DEPTH       = 8;
	localparam int          BIT_CNT_W        = 4;
	localparam logic [3:0]  DIN_OUT_END_RISE = 4'hC;
	localparam logic [2:0]  MODE_SHARED_DIN  = 3'h1;
	localparam logic [2:0]  MODE_INT_CLK_A   = 3'h4;
	localparam logic [2:0]  MODE_INT_CLK_B   = 3'h5;
	localparam logic [1:0]  CAL_SEL_FULL     = 2'h0;
	localparam logic [1:0]  CAL_SEL_DAC      = 2'h1;
	localparam logic [1:0]  CAL_SEL_OFS      = 2'h2;
	localparam int          SYN_W            = 7;
	localparam logic [6:0]  SYN_RST          = 7'h31;
	localparam int          SY_CONV          = 0;
	localparam int          SY_CAL           = 1;
	localparam int          SY_MCLK          = 2;
	localparam int          SY_SCLK          = 3;
	localparam int          SY_FRAME         = 4;
	localparam int          SY_POL           = 5;
	localparam int          SY_DIN           = 6;
	typedef enum logic [1:0] {ACS_IDLE, ACS_CONV, ACS_CAL} acs_state_type;
endpackage

// ===== hw/acs_top.sv
// converter sequencing, calibration timing and serial port
`timescale 1ns/100ps
`default_nettype none
module acs_top
	import acs_pkg::*;
#(
	parameter int CAL_FULL = CAL_FULL_PERIODS,
	parameter int CAL_DAC  = CAL_DAC_PERIODS,
	parameter int CAL_OFS  = CAL_OFS_PERIODS,
	parameter int DEPTH    = FIFO_DEPTH
) (
	input  wire logic              REF_CLK_IN,
	input  wire logic              SYS_RST_IN,
	input  wire logic              CE_IN,
	input  wire logic              MASTER_CLOCK_IN,
	input  wire logic              CONVERSION_START_N_IN,
	input  wire logic              SW_START_IN,
	input  wire logic              CAL_REQ_IN,
	input  wire logic [1:0]        CAL_SEL_IN,
	input  wire logic [2:0]        MODE_IN,
	input  wire logic              EDGE_SEL_IN,
	input  wire logic [DATA_W-1:0] SAMPLE_DATA_IN,
	input  wire logic              SCLK_IN,
	output logic                   SCLK_OUT,
	output logic                   SCLK_OE_OUT,
	input  wire logic              FRAME_N_IN,
	output logic                   DOUT_OUT,
	output logic                   DOUT_OE_OUT,
	input  wire logic              DIN_IN,
	output logic                   DIN_OUT,
	output logic                   DIN_OE_OUT,
	output logic                   BUSY_OUT,
	output logic [DATA_W-1:0]      RX_DATA_OUT,
	output logic                   RX_VALID_OUT
);
	////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [SYN_W-1:0] s1_reg;
	logic [SYN_W-1:0] s2_reg;
	logic [SYN_W-1:0] s3_reg;
	logic [SYN_W-1:0] pins;

	always_comb begin
		pins = {DIN_IN, EDGE_SEL_IN, FRAME_N_IN, SCLK_IN, MASTER_CLOCK_IN, CAL_REQ_IN, CONVERSION_START_N_IN};
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			s1_reg <= SYN_RST;
			s2_reg <= SYN_RST;
			s3_reg <= SYN_RST;
		end else if (CE_IN) begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// edge detection
	logic m_rise;
	logic start_fall;
	logic cal_rise;
	logic int_clk;
	logic src_rise;
	logic src_fall;
	logic act_rise;
	logic act_fall;
	logic frame_fall;
	logic frame_rise;
	logic pol;

	always_comb begin
		m_rise     = s2_reg[SY_MCLK] & ~s3_reg[SY_MCLK];
		start_fall = ~s2_reg[SY_CONV] & s3_reg[SY_CONV];
		cal_rise   = s2_reg[SY_CAL] & ~s3_reg[SY_CAL];
		int_clk    = (MODE_IN == MODE_INT_CLK_A) || (MODE_IN == MODE_INT_CLK_B);
		pol        = s2_reg[SY_POL];
		if (int_clk) begin
			src_rise = m_rise;
			src_fall = ~s2_reg[SY_MCLK] & s3_reg[SY_MCLK];
		end else begin
			src_rise = s2_reg[SY_SCLK] & ~s3_reg[SY_SCLK];
			src_fall = ~s2_reg[SY_SCLK] & s3_reg[SY_SCLK];
		end
		act_rise   = pol ? src_rise : src_fall;
		act_fall   = pol ? src_fall : src_rise;
		frame_fall = ~s2_reg[SY_FRAME] & s3_reg[SY_FRAME];
		frame_rise = s2_reg[SY_FRAME] & ~s3_reg[SY_FRAME];
	end

	////////////////////////////////////////////////////////////////
	// conversion and calibration sequencer
	acs_state_type      state_reg;
	acs_state_type      state_next;
	logic [CNT_W-1:0]   cnt_reg;
	logic [CNT_W-1:0]   cnt_next;
	logic [CNT_W-1:0]   target_reg;
	logic [CNT_W-1:0]   target_next;
	logic               busy_reg;
	logic               busy_next;
	logic               push_valid;
	logic               push_ready;
	logic               at_end;

	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		target_next = target_reg;
		at_end      = m_rise && (cnt_reg == target_reg);
		push_valid  = (state_reg == ACS_CONV) && at_end;
		case (state_reg)
			ACS_IDLE: begin
				cnt_next = '0;
				if (cal_rise) begin
					state_next = ACS_CAL;
					case (CAL_SEL_IN)
						CAL_SEL_DAC: target_next = CNT_W'(CAL_DAC - 1);
						CAL_SEL_OFS: target_next = CNT_W'(CAL_OFS - 1);
						default:     target_next = CNT_W'(CAL_FULL - 1);
					endcase
				end else if (start_fall || SW_START_IN) begin
					state_next  = ACS_CONV;
					target_next = CNT_W'(CONV_PERIODS - 1);
				end
			end
			ACS_CONV: begin
				// a full result buffer holds the conversion open
				if (at_end) begin
					if (push_ready) begin
						state_next = ACS_IDLE;
					end
				end else if (m_rise) begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ACS_CAL: begin
				if (at_end) begin
					state_next = ACS_IDLE;
				end else if (m_rise) begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			default: state_next = ACS_IDLE;
		endcase
		busy_next = state_next != ACS_IDLE;
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			state_reg  <= ACS_IDLE;
			cnt_reg    <= '0;
			target_reg <= '0;
			busy_reg   <= 1'b0;
		end else if (CE_IN) begin
			state_reg  <= state_next;
			cnt_reg    <= cnt_next;
			target_reg <= target_next;
			busy_reg   <= busy_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// result buffer
	logic              pop_valid;
	logic              pop_ready;
	logic [DATA_W-1:0] pop_data;

	acs_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_in        (REF_CLK_IN),
		.rst_in        (SYS_RST_IN),
		.ce_in         (CE_IN),
		.in_valid_in   (push_valid),
		.in_ready_out  (push_ready),
		.in_data_in    (SAMPLE_DATA_IN),
		.out_valid_out (pop_valid),
		.out_ready_in  (pop_ready),
		.out_data_out  (pop_data)
	);

	////////////////////////////////////////////////////////////////
	// serial port
	logic [DATA_W-1:0]    shift_reg;
	logic [DATA_W-1:0]    shift_next;
	logic [DATA_W-1:0]    rx_reg;
	logic [DATA_W-1:0]    rx_next;
	logic [DATA_W-1:0]    rx_out_reg;
	logic [DATA_W-1:0]    rx_out_next;
	logic                 rx_valid_reg;
	logic                 rx_valid_next;
	logic [BIT_CNT_W-1:0] rises_reg;
	logic [BIT_CNT_W-1:0] rises_next;
	logic                 framed_reg;
	logic                 framed_next;
	logic                 got_rise_reg;
	logic                 got_rise_next;
	logic                 dout_oe_reg;
	logic                 dout_oe_next;
	logic                 din_oe_reg;
	logic                 din_oe_next;
	logic                 sclk_reg;
	logic                 sclk_next;

	always_comb begin
		shift_next    = shift_reg;
		rx_next       = rx_reg;
		rx_out_next   = rx_out_reg;
		rx_valid_next = 1'b0;
		rises_next    = rises_reg;
		framed_next   = framed_reg;
		got_rise_next = got_rise_reg;
		dout_oe_next  = dout_oe_reg;
		din_oe_next   = din_oe_reg;
		pop_ready     = 1'b0;
		// generated clock copies the master clock: phases inherit its 40/60 bound
		sclk_next     = (int_clk && framed_reg) ? s2_reg[SY_MCLK] : pol;
		if (frame_fall) begin
			framed_next   = 1'b1;
			dout_oe_next  = 1'b1;
			shift_next    = pop_valid ? pop_data : '0;
			pop_ready     = pop_valid;
			rises_next    = '0;
			got_rise_next = 1'b0;
			rx_next       = '0;
		end else if (frame_rise) begin
			framed_next   = 1'b0;
			dout_oe_next  = 1'b0;
			din_oe_next   = 1'b0;
			rx_out_next   = rx_reg;
			rx_valid_next = framed_reg;
		end else if (framed_reg) begin
			if (act_rise) begin
				got_rise_next = 1'b1;
				rises_next    = rises_reg + 1'b1;
				if (!din_oe_reg) begin
					rx_next = {rx_reg[DATA_W-2:0], s2_reg[SY_DIN]};
				end
				if (MODE_IN == MODE_SHARED_DIN) begin
					if (rises_reg == '0) begin
						din_oe_next = 1'b1;
					end else if (rises_reg == DIN_OUT_END_RISE) begin
						din_oe_next = 1'b0;
					end
				end
			end else if (act_fall && got_rise_reg) begin
				shift_next    = {shift_reg[DATA_W-2:0], 1'b0};
				got_rise_next = 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			shift_reg    <= '0;
			rx_reg       <= '0;
			rx_out_reg   <= '0;
			rx_valid_reg <= 1'b0;
			rises_reg    <= '0;
			framed_reg   <= 1'b0;
			got_rise_reg <= 1'b0;
			dout_oe_reg  <= 1'b0;
			din_oe_reg   <= 1'b0;
			sclk_reg     <= 1'b1;
		end else if (CE_IN) begin
			shift_reg    <= shift_next;
			rx_reg       <= rx_next;
			rx_out_reg   <= rx_out_next;
			rx_valid_reg <= rx_valid_next;
			rises_reg    <= rises_next;
			framed_reg   <= framed_next;
			got_rise_reg <= got_rise_next;
			dout_oe_reg  <= dout_oe_next;
			din_oe_reg   <= din_oe_next;
			sclk_reg     <= sclk_next;
		end
	end

	always_comb begin
		BUSY_OUT     = busy_reg;
		SCLK_OUT     = sclk_reg;
		SCLK_OE_OUT  = int_clk;
		DOUT_OUT     = shift_reg[DATA_W-1];
		DOUT_OE_OUT  = dout_oe_reg;
		DIN_OUT      = shift_reg[DATA_W-1];
		DIN_OE_OUT   = din_oe_reg;
		RX_DATA_OUT  = rx_out_reg;
		RX_VALID_OUT = rx_valid_reg;
	end
endmodule
`default_nettype wire

// ===== tb/acs_host_model.sv
// host side of the serial port
`timescale 1ns/100ps
`default_nettype none
module acs_host_model (
	input  wire logic clk_in,
	input  wire logic mclk_in,
	input  wire logic pol_in,
	input  wire logic sclk_dev_in,
	input  wire logic dout_in,
	input  wire logic dout_oe_in,
	input  wire logic din_dev_in,
	input  wire logic din_oe_in,
	output logic      frame_n_out,
	output logic      sclk_out,
	output logic      din_out
);
	logic lvl = 1'h0;
	logic drv = 1'h0;
	logic bv  = 1'h0;
	logic tg  = 1'h0;
	logic sdo;
	initial frame_n_out = 1'h1;
	// released lines wander so a stale bit never passes
	always @(posedge clk_in) tg <= ~tg;
	assign sdo = dout_oe_in ? dout_in : tg;
	assign din_out = din_oe_in ? din_dev_in : (drv ? bv : tg);
	assign sclk_out = lvl ^ ~pol_in;
	////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic xfer(input logic [11:0] tx, input int n, input bit ext, input bit own,
			output logic [11:0] rx, output bit ok);
		logic [11:0] sh;
		logic        p;
		int          k;
		int          t;
		sh = tx;
		rx = 12'h000;
		k = 0;
		t = 0;
		bv = sh[11];
		drv = own;
		// lowered just after a master rise: the copied clock falls about six cycles later
		if (!ext) do begin
			p = mclk_in;
			cyc(1);
			t++;
		end while (!(!p && mclk_in) && t < 20);
		frame_n_out = 1'h0;
		if (ext) begin
			cyc(8);
			for (k = 0; k < n; k++) begin
				rx = {rx[10:0], sdo};
				lvl = 1'h1; // 8 cycles a bit stays under 4 MHz
				cyc(4);
				lvl = 1'h0;
				sh = sh << 1;
				bv = sh[11]; // set long before the sampling edge
				cyc(4);
			end
		end else begin
			p = sclk_dev_in;
			for (t = 0; t < 200 && k < n; t++) begin
				cyc(1);
				if (sclk_dev_in && !p) begin
					rx = {rx[10:0], sdo};
					k++;
				end
				if (!sclk_dev_in && p && k > 0) begin
					sh = sh << 1;
					bv = sh[11];
				end
				p = sclk_dev_in;
			end
		end
		ok = (k == n);
		cyc(2);
		frame_n_out = 1'h1;
		drv = 1'h0;
		cyc(6);
	endtask
endmodule
`default_nettype wire

// ===== tb/acs_top_asserts.sv
// port checks for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module acs_top_asserts
	import acs_pkg::*;
(
	input wire logic       REF_CLK_IN,
	input wire logic       SYS_RST_IN,
	input wire logic       CONVERSION_START_N_IN,
	input wire logic [2:0] MODE_IN,
	input wire logic       EDGE_SEL_IN,
	input wire logic       SCLK_IN,
	input wire logic       FRAME_N_IN,
	input wire logic       SCLK_OUT,
	input wire logic       SCLK_OE_OUT,
	input wire logic       DOUT_OUT,
	input wire logic       DOUT_OE_OUT,
	input wire logic       DIN_OE_OUT,
	input wire logic       BUSY_OUT,
	input wire logic       RX_VALID_OUT
);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	////////////////////////////////////////////////////////////
	a_busy_rise: assert property ($fell(CONVERSION_START_N_IN) && !BUSY_OUT |-> ##[1:5] BUSY_OUT)
		else $error("busy late");
	a_busy_hold: assert property ($rose(BUSY_OUT) |-> BUSY_OUT[*8])
		else $error("busy too short");
	a_dout_on: assert property ((!FRAME_N_IN)[*6] |-> DOUT_OE_OUT)
		else $error("data out not driven");
	a_dout_off: assert property (FRAME_N_IN[*6] |-> !DOUT_OE_OUT && !DIN_OE_OUT)
		else $error("data out not released");
	a_rx_pulse: assert property (RX_VALID_OUT |-> $fell(DOUT_OE_OUT) ##1 !RX_VALID_OUT)
		else $error("receive pulse wrong");
	a_sclk_dir: assert property (SCLK_OE_OUT == (MODE_IN == MODE_INT_CLK_A || MODE_IN == MODE_INT_CLK_B))
		else $error("shift clock direction");
	a_din_mode: assert property (DIN_OE_OUT |-> MODE_IN == MODE_SHARED_DIN && DOUT_OE_OUT)
		else $error("data in driven");
	a_sclk_idle: assert property ((FRAME_N_IN && $stable(EDGE_SEL_IN))[*6] |-> SCLK_OUT == EDGE_SEL_IN)
		else $error("shift clock idle level");
	a_sclk_high: assert property ($rose(SCLK_OUT) && !FRAME_N_IN && SCLK_OE_OUT |-> SCLK_OUT[*3])
		else $error("shift clock high short");
	// a held host clock high means no falling edge to act on
	a_dout_hold: assert property ((DOUT_OE_OUT && !SCLK_OE_OUT && EDGE_SEL_IN && SCLK_IN)[*3]
			|-> $stable(DOUT_OUT))
		else $error("data out moved");
endmodule
`default_nettype wire

// ===== tb/acs_top_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module acs_top_tb
	import acs_pkg::*;
;
	logic              clk = 1'h0;
	logic              rst = 1'h1;
	logic              mclk = 1'h0;
	logic              st_n = 1'h1;
	logic              sw = 1'h0;
	logic              cal = 1'h0;
	logic [1:0]        sel = 2'h0;
	logic [2:0]        mode = 3'h2;
	logic              esel = 1'h1;
	logic [DATA_W-1:0] sd = 12'h000;
	logic [DATA_W-1:0] rxd;
	logic [11:0]       rw;
	logic [11:0]       q[$];
	logic              frame_n, sclk_h, din_w, sclk_o, sclk_oe, dout, dout_oe, din_o, din_oe, busy, rxv;
	bit                ok;
	int                n_errors = 0;
	int                compares = 0;
	always #25 clk = ~clk;
	initial begin
		#7;
		forever #200 mclk = ~mclk;
	end
	acs_top #(.CAL_FULL(40), .CAL_DAC(30), .CAL_OFS(20), .DEPTH(8)) DUT (
		.REF_CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'h1), .MASTER_CLOCK_IN(mclk),
		.CONVERSION_START_N_IN(st_n), .SW_START_IN(sw), .CAL_REQ_IN(cal), .CAL_SEL_IN(sel),
		.MODE_IN(mode), .EDGE_SEL_IN(esel), .SAMPLE_DATA_IN(sd), .SCLK_IN(sclk_h),
		.SCLK_OUT(sclk_o), .SCLK_OE_OUT(sclk_oe), .FRAME_N_IN(frame_n), .DOUT_OUT(dout),
		.DOUT_OE_OUT(dout_oe), .DIN_IN(din_w), .DIN_OUT(din_o), .DIN_OE_OUT(din_oe),
		.BUSY_OUT(busy), .RX_DATA_OUT(rxd), .RX_VALID_OUT(rxv));
	acs_host_model host (.clk_in(clk), .mclk_in(mclk), .pol_in(esel), .sclk_dev_in(sclk_o),
		.dout_in(dout), .dout_oe_in(dout_oe), .din_dev_in(din_o), .din_oe_in(din_oe),
		.frame_n_out(frame_n), .sclk_out(sclk_h), .din_out(din_w));
	////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict;
		if (n_errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic limit(input bit late);
		if (late) begin
			n_errors++;
			print_verdict;
		end
	endtask
	// first master rise may land before the take, so n-1 is fair
	task automatic busy_len(input string what, input int n);
		int   t;
		int   c;
		logic p;
		c = 0;
		for (t = 0; busy !== 1'h1 && t < 10; t++) cyc(1);
		check("busy rise", busy, 1'h1);
		limit(t >= 10);
		p = mclk;
		for (t = 0; busy === 1'h1 && t < n * 8 + 40; t++) begin
			cyc(1);
			c += (mclk && !p);
			p = mclk;
		end
		limit(busy !== 1'h0);
		check(what, c == n || c == n - 1, 1'h1);
	endtask
	task automatic pulse(input bit c);
		if (c) cal = 1'h1;
		else st_n = 1'h0;
		cyc(3);
		cal = 1'h0;
		st_n = 1'h1;
	endtask
	task automatic t_cal;
		int len [4] = '{40, 30, 20, 40};
		for (int i = 0; i < 4; i++) begin
			sel = i[1:0];
			pulse(1'h1);
			busy_len("calibration", len[i]);
			cyc(10);
		end
	endtask
	task automatic t_conv;
		sd = 12'hA5C;
		q.push_back(sd);
		pulse(1'h0);
		busy_len("conversion", CONV_PERIODS);
		cyc(10); // acquisition gap kept by the host
		sd = 12'h5A3;
		q.push_back(sd);
		sw = 1'h1;
		cyc(1);
		sw = 1'h0;
		busy_len("software start", CONV_PERIODS);
		cyc(10);
	endtask
	// buffer filled past full, then drained in every port mode
	task automatic t_fill;
		logic [11:0] ex;
		logic [11:0] tx;
		int          c;
		int          v;
		int          m;
		for (int i = 0; i < 7; i++) begin
			sd = 12'h111 * 12'(i) + 12'h00F;
			q.push_back(sd);
			cyc(6); // acquisition gap before the next start edge
			pulse(1'h0);
			if (i < 6) busy_len("conversion", CONV_PERIODS);
		end
		cyc(300);
		check("busy while full", busy, 1'h1);
		for (int i = 0; i < 10; i++) begin
			mode = (i == 5) ? MODE_INT_CLK_A : (i == 6) ? MODE_INT_CLK_B : (i == 7) ? MODE_SHARED_DIN : 3'h2;
			esel = (i != 3);
			cyc(8);
			ex = (i < 9) ? q.pop_front() : 12'h000;
			tx = 12'h3C0 ^ 12'(i);
			c = 0;
			v = 0;
			m = 0;
			fork
				host.xfer(tx, (i == 7) ? 13 : 12, !(i == 5 || i == 6), i != 7, rw, ok);
				// runs on until the port has let go, so the end-of-frame strobe is seen
				for (int t = 0; t < 300 && !(frame_n && t > 30 && !dout_oe); t++) begin
					cyc(1);
					c += din_oe;
					v += rxv;
					m += din_oe && (din_o !== dout);
				end
			join
			limit(!ok);
			check("receive strobe", v == 1, 1'h1);
			check("shared pin data", m == 0, 1'h1);
			check("serial word", rw, (i == 7) ? {ex[10:0], 1'h0} : ex);
			if (i != 7) check("received word", rxd, tx);
			else check("shared pin cycles", c >= 94 && c <= 98, 1'h1);
			if (i == 0) check("busy after read", busy, 1'h0);
		end
	endtask
	initial begin
		cyc(16);
		rst = 1'h0;
		cyc(2);
		check("reset outputs", {busy, dout_oe, din_oe, rxv, sclk_o}, 5'h01);
		t_cal;
		t_conv;
		t_fill;
		print_verdict;
	end
endmodule
bind acs_top acs_top_asserts u_chk (.REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
	.CONVERSION_START_N_IN(CONVERSION_START_N_IN), .MODE_IN(MODE_IN), .EDGE_SEL_IN(EDGE_SEL_IN),
	.SCLK_IN(SCLK_IN), .FRAME_N_IN(FRAME_N_IN), .SCLK_OUT(SCLK_OUT), .SCLK_OE_OUT(SCLK_OE_OUT),
	.DOUT_OUT(DOUT_OUT), .DOUT_OE_OUT(DOUT_OE_OUT), .DIN_OE_OUT(DIN_OE_OUT), .BUSY_OUT(BUSY_OUT),
	.RX_VALID_OUT(RX_VALID_OUT));
`default_nettype wire
